/* File: verilog/ps_config_pkg.sv */
package ps_config_pkg;
    // clocking and timing
    localparam int CLK_HZ         = 100_000_000;
    localparam int POR_TIME_MS    = 100;
    localparam int POR_CYCLES     = CLK_HZ / 1000 * POR_TIME_MS;
    localparam int ERR_TIME_US    = 30;
    localparam int ERR_CYCLES     = CLK_HZ / 1_000_000 * ERR_TIME_US;
    localparam int INT_OSC_HZ     = 10_000_000;
    localparam int OSC_DIV        = CLK_HZ / INT_OSC_HZ;
    localparam int INIT_CYCLES    = 136;
    localparam int INIT_HOLD_BITS = 136;
    // apb register map
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] BITCNT_OFS = 8'h08;
    localparam int CTRL_AUTO_BIT  = 0;
    localparam int CTRL_INIT_BIT  = 1;
    localparam int CTRL_UCLK_BIT  = 2;
    localparam logic CTRL_AUTO_RST = 1'b1;
    localparam logic CTRL_INIT_RST = 1'b0;
    localparam logic CTRL_UCLK_RST = 1'b0;
    localparam int STATUS_ERR_BIT = 3;
    // synchronised input positions
    localparam int IN_REQ  = 0;
    localparam int IN_SCLK = 1;
    localparam int IN_SDAT = 2;
    localparam int IN_STAT = 3;
    localparam int IN_DONE = 4;
    localparam int IN_UCLK = 5;
    localparam int IN_CEN  = 6;
    localparam int IN_W    = 7;

    typedef enum logic [2:0] {
        ST_POR  = 3'h0,
        ST_WAIT = 3'h1,
        ST_LOAD = 3'h3,
        ST_INIT = 3'h2,
        ST_USER = 3'h6,
        ST_ERR  = 3'h4
    } cfg_state_t;
endpackage

/* File: verilog/passive_serial_config_port.sv */
// Summary of operation
// RULE1: programmer holds chain enable high and request low while reprogramming the memory
// RULE2: host-driven mode captures one data bit on each serial clock rising edge
// RULE3: completion held low in power-up and loading; pulled low again on request
// RULE4: user I/O stays tri-stated with pull-ups until initialization ends
// RULE5: init-complete stays high before and during first 136 bits, when enabled
// RULE6: host parks the serial clock at a fixed level in user mode
// RULE7: host parks the serial data at a fixed level in user mode
// RULE8: request low-to-high starts loading and pulls completion low to select memory
// RULE9: status held low during power-on reset, released on exit
// RULE10: memory holds the status line low during its own power-on delay
// RULE11: no data starts until every party has released the status line
// RULE12: after the last bit, release completion and initialize from internal oscillator
// RULE13: configuration error drives status low, resetting loader and memory
// RULE14: with auto-restart on, retry configuration without an external request
// RULE15: with auto-restart off, host watches status and pulses request low
// RULE16: memory parks serial clock low and is deselected when completion rises
// RULE17: memory waits 64 clocks for completion, else pulses its enable low
// RULE18: with auto-restart, release status after timeout; memory restarts then
// RULE19: shared completion line initializes devices together; nobody holds it low
// RULE20: completion released within first init cycles; user clock waits for ticks
// RULE21: init-complete rises only when initialization finishes, entering user mode; the code also releases it on request low or a load error
// RULE22: host holds request low at least 40 us for reconfiguration
// RULE23: auto-restart releases status about 30 us after an error
// RULE24: open-drain lines are drive-low-or-release with a pull-up
//
// The address map and register access over APB were chosen for this implementation.
module passive_serial_config_port
    import ps_config_pkg::*;
#(
    parameter int POR_CNT    = POR_CYCLES,
    parameter int ERR_CNT    = ERR_CYCLES,
    parameter int CFG_BITS   = 4096,
    parameter int FRAME_BITS = 32
) (
    input  wire logic        REF_CLK,                // 100 MHz clock
    input  wire logic        ARST_N,                 // async reset
    input  wire logic        PSEL,                   // apb select
    input  wire logic        PENABLE,                // apb enable
    input  wire logic        PWRITE,                 // apb direction
    input  wire logic [7:0]  PADDR,                  // apb byte address
    input  wire logic [31:0] PWDATA,                 // apb write data
    output logic      [31:0] PRDATA,                 // apb read data
    output logic             PREADY,                 // apb ready
    output logic             PSLVERR,                // apb error
    input  wire logic        CONFIG_REQUEST_N,       // request pin
    input  wire logic        SERIAL_CONFIG_CLOCK,    // host serial clock
    input  wire logic        SERIAL_CONFIG_DATA_IN,  // host serial data
    input  wire logic        CHAIN_ENABLE_IN_N,      // chain enable pin
    input  wire logic        USER_STARTUP_CLOCK,     // user init clock
    input  wire logic        STATUS_ERROR_N_IN,      // status line level
    output logic             STATUS_ERROR_N_OUT,     // status drive value
    output logic             STATUS_ERROR_N_OE,      // status drive low
    input  wire logic        CONFIG_COMPLETE_IN,     // completion line level
    output logic             CONFIG_COMPLETE_OUT,    // completion drive value
    output logic             CONFIG_COMPLETE_OE,     // completion drive low
    output logic             INIT_COMPLETE_OUT,      // init pin drive value
    output logic             INIT_COMPLETE_OE,       // init pin drive low
    output logic             USER_IO_ENABLE,         // user i/o active
    output logic             CONFIG_BIT,             // captured bit
    output logic             CONFIG_BIT_VALID        // captured bit strobe
);
    localparam int DIV_W = $clog2(OSC_DIV);

    if (FRAME_BITS < 2 || FRAME_BITS > 65535 || CFG_BITS % FRAME_BITS != 0 ||
        POR_CNT < 1 || ERR_CNT < 1 || OSC_DIV < 2) begin : g_chk
        $error("unsupported parameter values");
    end

    typedef struct packed {
        logic [IN_W-1:0] s1;
        logic [IN_W-1:0] s2;
        logic [IN_W-1:0] s3;
        logic [IN_W-1:0] flt;
        cfg_state_t      st;
        logic [31:0]     cnt;
        logic [31:0]     bits;
        logic [15:0]     frm;
        logic            par;
        logic [DIV_W-1:0] div;
        logic            auto_rst;
        logic            init_en;
        logic            uclk_sel;
        logic            err_flag;
        logic            stat_oe;
        logic            done_oe;
        logic            init_oe;
        logic            uio_en;
        logic            od_lvl;
        logic            bit_q;
        logic            bit_vld;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } port_state_t;

    port_state_t     r, n;
    logic [IN_W-1:0] rise;
    logic            itick;
    logic            d;
    logic            bad;

    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        case (a)
            CTRL_OFS:   reg_sel = 2'h0;
            STATUS_OFS: reg_sel = 2'h1;
            BITCNT_OFS: reg_sel = 2'h2;
            default:    reg_sel = 2'h3;
        endcase
    endfunction

    always_comb begin
        n = r;
        n.s1 = {CHAIN_ENABLE_IN_N, USER_STARTUP_CLOCK, CONFIG_COMPLETE_IN,
                STATUS_ERROR_N_IN, SERIAL_CONFIG_DATA_IN, SERIAL_CONFIG_CLOCK, CONFIG_REQUEST_N};
        n.s2 = r.s1;
        n.s3 = r.s2;
        // a change counts once the second and third stages agree
        n.flt = (r.flt & (r.s2 ^ r.s3)) | (r.s3 & ~(r.s2 ^ r.s3));
        rise = n.flt & ~r.flt;
        n.div = (r.div == DIV_W'(OSC_DIV - 1)) ? '0 : r.div + 1'b1;
        itick = r.uclk_sel ? rise[IN_UCLK] : (r.div == DIV_W'(OSC_DIV - 1));
        n.bit_vld = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.od_lvl = 1'b0;
        d = n.flt[IN_SDAT];
        bad = 1'b0;

        // apb: setup cycle prepares the answer, access cycle completes it
        if (PSEL && !PENABLE) begin
            n.pready = 1'b1;
            n.pslverr = (reg_sel(PADDR) == 2'h3);
            case (reg_sel(PADDR))
                2'h0:    n.prdata = {29'h0, r.uclk_sel, r.init_en, r.auto_rst};
                2'h1:    n.prdata = {28'h0, r.err_flag, r.st};
                2'h2:    n.prdata = r.bits;
                default: n.prdata = 32'h0;
            endcase
        end
        if (PSEL && PENABLE && r.pready && PWRITE) begin
            case (reg_sel(PADDR))
                2'h0: begin
                    n.auto_rst = PWDATA[CTRL_AUTO_BIT];
                    n.init_en = PWDATA[CTRL_INIT_BIT];
                    n.uclk_sel = PWDATA[CTRL_UCLK_BIT];
                end
                2'h1: if (PWDATA[STATUS_ERR_BIT]) n.err_flag = 1'b0;
                default: ;
            endcase
        end

        case (r.st)
            ST_POR: begin
                n.stat_oe = 1'b1;                                   // RULE9
                n.done_oe = 1'b1;                                   // RULE3
                n.cnt = r.cnt + 32'h1;
                if (r.cnt == 32'(POR_CNT - 1)) begin
                    n.st = ST_WAIT;
                    n.stat_oe = 1'b0;                               // RULE9
                    n.cnt = '0;
                end
            end
            ST_WAIT: begin
                n.stat_oe = 1'b0;
                n.done_oe = 1'b1;                                   // RULE8
                n.bits = '0;
                n.frm = '0;
                n.par = 1'b0;
                // start once request is high, status line released and chain enabled
                if (r.flt[IN_REQ] && r.flt[IN_STAT] && !r.flt[IN_CEN])  // RULE8 RULE11 RULE1
                    n.st = ST_LOAD;
            end
            ST_LOAD: begin
                if (!r.flt[IN_STAT]) begin
                    bad = 1'b1;                                     // RULE13
                end else if (rise[IN_SCLK]) begin
                    n.bit_q = d;                                    // RULE2
                    n.bit_vld = 1'b1;
                    n.bits = r.bits + 32'h1;
                    n.par = r.par ^ d;
                    n.frm = r.frm + 16'h1;
                    if (r.frm == 16'(FRAME_BITS - 1)) begin
                        // even parity over each frame, last bit included
                        bad = r.par ^ d;
                        n.frm = '0;
                        n.par = 1'b0;
                    end
                    if (!bad && r.bits == 32'(CFG_BITS - 1)) begin
                        n.st = ST_INIT;                             // RULE12
                        n.cnt = '0;
                    end
                end
                if (bad) begin
                    n.st = ST_ERR;
                    n.stat_oe = 1'b1;                               // RULE13
                    n.cnt = '0;
                end
            end
            ST_INIT: begin
                if (itick && r.done_oe) begin
                    n.done_oe = 1'b0;                               // RULE12 RULE20
                end else if (itick && r.flt[IN_DONE]) begin
                    n.cnt = r.cnt + 32'h1;                          // RULE19
                    if (r.cnt == 32'(INIT_CYCLES - 1))
                        n.st = ST_USER;                             // RULE21
                end
            end
            ST_USER: n.done_oe = 1'b0;
            ST_ERR: begin
                n.stat_oe = 1'b1;
                if (r.auto_rst) begin                               // RULE14
                    n.cnt = r.cnt + 32'h1;
                    if (r.cnt == 32'(ERR_CNT - 1)) begin
                        n.st = ST_WAIT;                             // RULE18 RULE23
                        n.stat_oe = 1'b0;
                        n.cnt = '0;
                    end
                end
            end
            default: n.st = ST_POR;
        endcase

        // request low resets the loader from any state after power-on
        if (r.st != ST_POR && !r.flt[IN_REQ]) begin
            n.st = ST_WAIT;                                         // RULE3
            n.stat_oe = 1'b1;
            n.done_oe = 1'b1;
            n.cnt = '0;
        end
        if (bad)
            n.err_flag = 1'b1;                                      // set beats clear
        n.uio_en = (n.st == ST_USER);                               // RULE4
        n.init_oe = r.init_en && ((n.st == ST_LOAD && n.bits >= 32'(INIT_HOLD_BITS)) ||
                                  n.st == ST_INIT);                 // RULE5 RULE21
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= '0;
            r.st <= ST_POR;
            r.stat_oe <= 1'b1;
            r.done_oe <= 1'b1;
            r.auto_rst <= CTRL_AUTO_RST;
            r.init_en <= CTRL_INIT_RST;
            r.uclk_sel <= CTRL_UCLK_RST;
        end else begin
            r <= n;
        end
    end

    // open-drain lines only ever drive low
    assign STATUS_ERROR_N_OUT  = r.od_lvl;                          // RULE24
    assign STATUS_ERROR_N_OE   = r.stat_oe;
    assign CONFIG_COMPLETE_OUT = r.od_lvl;
    assign CONFIG_COMPLETE_OE  = r.done_oe;
    assign INIT_COMPLETE_OUT   = r.od_lvl;
    assign INIT_COMPLETE_OE    = r.init_oe;
    assign USER_IO_ENABLE      = r.uio_en;
    assign CONFIG_BIT          = r.bit_q;
    assign CONFIG_BIT_VALID    = r.bit_vld;
    assign PRDATA              = r.prdata;
    assign PREADY              = r.pready;
    assign PSLVERR             = r.pslverr;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_reset_held;
        r.st == ST_WAIT && r.done_oe && r.stat_oe;
    endsequence
    sequence s_loading;
        r.st == ST_LOAD && r.flt[IN_REQ] && r.flt[IN_STAT];
    endsequence

    property p_capture;
        s_loading and rise[IN_SCLK] |=> r.bit_vld && r.bit_q == $past(n.flt[IN_SDAT]) ||
                                        r.st != ST_LOAD;
    endproperty
    a_capture: assert property (p_capture) else $error("bit not captured"); // RULE2
    property p_done_low;
        r.st == ST_POR || r.st == ST_WAIT || r.st == ST_LOAD |-> r.done_oe;
    endproperty
    a_done_low: assert property (p_done_low) else $error("completion released early"); // RULE3
    property p_req_reset;
        r.st != ST_POR && !r.flt[IN_REQ] |=> s_reset_held;
    endproperty
    a_req_reset: assert property (p_req_reset) else $error("request low ignored"); // RULE3
    property p_uio;
        $rose(r.uio_en) |-> $past(r.st) == ST_INIT && !r.init_oe;
    endproperty
    a_uio: assert property (p_uio) else $error("user mode without init"); // RULE4
    property p_init_early;
        r.st == ST_WAIT || r.bits < 32'(INIT_HOLD_BITS) && r.st == ST_LOAD |-> !r.init_oe;
    endproperty
    a_init_early: assert property (p_init_early) else $error("init pin low too early"); // RULE5
    property p_start;
        r.st == ST_WAIT && r.flt[IN_REQ] && r.flt[IN_STAT] && !r.flt[IN_CEN]
            |=> r.st == ST_LOAD && r.done_oe;
    endproperty
    a_start: assert property (p_start) else $error("load did not start"); // RULE8
    property p_por;
        r.st == ST_POR |-> r.stat_oe ##1 (r.st == ST_POR || !r.stat_oe || !r.flt[IN_REQ]);
    endproperty
    a_por: assert property (p_por) else $error("status not released after por"); // RULE9
    property p_err;
        s_loading and (r.frm == 16'(FRAME_BITS - 1)) and rise[IN_SCLK] and (r.par != n.flt[IN_SDAT])
            |=> r.st == ST_ERR && r.stat_oe && r.err_flag;
    endproperty
    a_err: assert property (p_err) else $error("frame error missed"); // RULE13
    property p_restart;
        r.st == ST_ERR && r.auto_rst && r.flt[IN_REQ] && r.cnt == 32'(ERR_CNT - 1)
            |=> r.st == ST_WAIT && !r.stat_oe;
    endproperty
    a_restart: assert property (p_restart) else $error("no auto restart"); // RULE14
    property p_release;
        r.st == ST_INIT && r.flt[IN_REQ] && r.done_oe && itick |=> !r.done_oe ##1 !r.done_oe;
    endproperty
    a_release: assert property (p_release) else $error("completion not released"); // RULE20
endmodule

/* File: bench/cfg_memory_model.sv */
module cfg_memory_model #(
    parameter int CFG_BITS   = 64,
    parameter int FRAME_BITS = 16,
    parameter int POR_NS     = 2000
) (
    input  wire logic go,             // host allows loads
    input  wire logic corrupt,        // flip the first frame's parity bit
    input  wire logic status_line,    // wired status level
    input  wire logic complete_line,  // wired completion level, low selects us
    output logic      sclk,           // serial clock
    output logic      sdat,           // serial data
    output logic      oe_low          // pulls the status line low
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    initial begin
        sclk = 1'b0;
        sdat = 1'b0;
        oe_low = 1'b1;
        #(POR_NS) oe_low = 1'b0;
        forever begin
            wait (go && status_line && !complete_line);
            #200;
            for (n = 0; n < CFG_BITS && status_line; n++) begin
                sdat = n[0] ^ n[2] ^ (corrupt && n == FRAME_BITS - 1);
                #60 sclk = 1'b1;
                #65 sclk = 1'b0;
            end
            // clock parked low, data held at a defined level
            #(64 * 125);
            if (n == CFG_BITS && status_line && !complete_line) begin
                oe_low = 1'b1;
                #3000 oe_low = 1'b0;
            end
        end
    end
endmodule

/* File: bench/passive_serial_config_port_bench.sv */
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
$display("ERROR at %0t: value %0h, expected %0h", $time, (got), (exp)); end end
`define WAITC(c, m) begin int w; w = 0; while (!(c) && w < (m)) begin @(posedge clk); w++; end \
`CHECK((c), 1'b1) end

module passive_serial_config_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ps_config_pkg::*;
    logic        clk, arst_n, psel, penable, pwrite, req_n, chain_n, uclk, uclk_on, go, corrupt, saw_init;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, sclk, sdat, mem_oe, status_oe, complete_oe, init_oe, user_io, cbit, cvalid;
    logic [2:0]  udiv;
    int          fails, checks_done, nbits;
    wire         status_line   = ~(status_oe | mem_oe);
    wire         complete_line = ~complete_oe;

    passive_serial_config_port #(.POR_CNT(20), .ERR_CNT(30), .CFG_BITS(64), .FRAME_BITS(16)) DUT (
        .REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CONFIG_REQUEST_N(req_n),
        .SERIAL_CONFIG_CLOCK(sclk), .SERIAL_CONFIG_DATA_IN(sdat), .CHAIN_ENABLE_IN_N(chain_n),
        .USER_STARTUP_CLOCK(uclk), .STATUS_ERROR_N_IN(status_line), .STATUS_ERROR_N_OUT(),
        .STATUS_ERROR_N_OE(status_oe), .CONFIG_COMPLETE_IN(complete_line), .CONFIG_COMPLETE_OUT(),
        .CONFIG_COMPLETE_OE(complete_oe), .INIT_COMPLETE_OUT(), .INIT_COMPLETE_OE(init_oe),
        .USER_IO_ENABLE(user_io), .CONFIG_BIT(cbit), .CONFIG_BIT_VALID(cvalid));

    cfg_memory_model MEM (.go(go), .corrupt(corrupt),
        .status_line(status_line), .complete_line(complete_line), .sclk(sclk), .sdat(sdat), .oe_low(mem_oe));

    always @(posedge clk) begin
        udiv <= udiv + 3'h1;
        uclk <= uclk_on & udiv[2];
        if (init_oe === 1'b1) saw_init <= 1'b1;
        if (cvalid === 1'b1) begin
            if (!corrupt) `CHECK(cbit, nbits[0] ^ nbits[2])
            nbits <= nbits + 1;
        end
    end

    task automatic complete_run();
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        `CHECK(pready, 1'b1)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_por();
        `CHECK(status_oe, 1'b1)
        `CHECK(complete_oe, 1'b1)
        `CHECK(user_io, 1'b0)
        repeat (30) @(posedge clk);
        `CHECK(status_oe, 1'b0)
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHECK(rd, 32'h00000001)
        apb(1'b1, CTRL_OFS, 32'h00000003);
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHECK(rd, 32'h00000003)
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        `CHECK({er, rd}, {1'b1, 32'h0})
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHECK(rd[2:0], 3'h1)
    endtask

    task automatic t_chain();
        chain_n <= 1'b1;
        req_n <= 1'b0;
        repeat (300) @(posedge clk);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHECK(rd[2:0], 3'h1)
        chain_n <= 1'b0;
        req_n <= 1'b1;
    endtask

    task automatic t_load(input logic init_en, input int tick);
        int cyc;
        saw_init = 1'b0;
        go = 1'b1;
        `WAITC(nbits >= 2, 3000)
        `CHECK(init_oe, 1'b0)
        `WAITC(complete_oe === 1'b0, 3000)
        cyc = 0;
        while (user_io !== 1'b1 && cyc < 3000) begin @(posedge clk); cyc++; end
        `CHECK(cyc >= 134 * tick && cyc <= 138 * tick, 1'b1)
        `CHECK(nbits, 64)
        `CHECK(init_oe, 1'b0)
        `CHECK(saw_init, init_en)
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHECK(rd[2:0], 3'h6)
        apb(1'b0, BITCNT_OFS, 32'h0);
        `CHECK(rd, 32'd64)
    endtask

    task automatic t_request();
        req_n <= 1'b0;
        repeat (8) @(posedge clk);
        `CHECK(complete_oe, 1'b1)
        `CHECK(user_io, 1'b0)
        repeat (4000) @(posedge clk);
        nbits = 0;
        req_n <= 1'b1;
    endtask

    task automatic t_err(input logic auto_on);
        int cyc;
        corrupt = 1'b1;
        t_request();
        `WAITC(nbits == 16, 3000)
        `WAITC(status_oe === 1'b1, 50)
        `CHECK(status_oe, 1'b1)
        corrupt = 1'b0;
        cyc = 0;
        while (status_oe === 1'b1 && cyc < 300) begin @(posedge clk); cyc++; end
        if (auto_on) `CHECK(cyc >= 25 && cyc <= 40, 1'b1)
        else `CHECK(cyc, 300)
        if (!auto_on) t_request();
        nbits = 0;
        t_load(auto_on, 10);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHECK(rd[STATUS_ERR_BIT], 1'b1)
        apb(1'b1, STATUS_OFS, 32'h00000008);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHECK(rd[STATUS_ERR_BIT], 1'b0)
    endtask

    task automatic t_user_clk();
        apb(1'b1, CTRL_OFS, 32'h00000005);
        t_request();
        `WAITC(nbits == 64, 3000)
        repeat (300) @(posedge clk);
        `CHECK(complete_oe, 1'b1)
        `CHECK(user_io, 1'b0)
        uclk_on <= 1'b1;
        t_load(1'b0, 8);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, chain_n, uclk, uclk_on, udiv} = '0;
        {go, corrupt, saw_init, rd, er} = '0;
        req_n = 1'b1;
        nbits = 0;
        fails = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_por();
        t_chain();
        t_load(1'b1, 10);
        t_err(1'b1);
        apb(1'b1, CTRL_OFS, 32'h0);
        t_err(1'b0);
        t_user_clk();
        complete_run();
    end

    initial begin
        #600_000;
        fails++;
        $display("ERROR at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
